// [src/pllcc_pkg.sv]
// constants and carrier types for the modulator clock control block
package pllcc_pkg;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CODE_W = 6;
    // register offsets
    localparam logic [9:0] OFS_PLL_ENABLE_CTRL = 10'h009;
    localparam logic [9:0] OFS_PLL_FACTOR_LOCK_CTRL = 10'h00a;
    localparam logic [9:0] OFS_REFERENCE_CTRL = 10'h018;
    localparam logic [9:0] OFS_RATE_CONVERTER_CTRL = 10'h101;
    // field positions
    localparam int unsigned POS_LOOP_ENABLE = 2;
    localparam int unsigned POS_AUTOBAND = 6;
    localparam int unsigned POS_LOCKED = 7;
    localparam int unsigned POS_VREF_OFF = 6;
    // reset values
    localparam logic [7:0] RST_PLL_ENABLE_CTRL = 8'h00;
    localparam logic [5:0] RST_FACTOR_CODE = 6'h00;
    localparam logic [7:0] RST_REFERENCE_CTRL = 8'h00;
    localparam logic [5:0] RST_RATE_CONVERTER = 6'h00;
    // factor decode bounds
    localparam logic [5:0] FACTOR_MIN = 6'h08;
    localparam logic [5:0] FACTOR_MAX = 6'h2a;
    // clock relations: modulator is oscillator / 2, bandwidth is mod / 64
    localparam int unsigned MOD_DIV = 2;
    localparam int unsigned BW_DIV = 64;
    localparam int unsigned BW_CYCLES = MOD_DIV * BW_DIV;
    localparam logic [6:0] BW_CNT_LAST = 7'(BW_CYCLES - 1);

    typedef struct packed {
        logic loop_en;
        logic mod_src_pll;
        logic autoband_en;
        logic vref_int_en;
        logic [5:0] factor_n;
        logic [5:0] rate_setting;
    } pllcc_cfg_t;
endpackage

// [src/pllcc_factor_decode.sv]
// multiplier code to supported factor decode
`timescale 1ns/1ns
module pllcc_factor_decode
    import pllcc_pkg::*;
(
    input wire logic [5:0] code,
    output logic [5:0] factor_n
);
    // largest supported factor not above the code, clamped 8..42
    wire logic [5:0] n_mid;
    assign n_mid = (code >= 6'h22) ? 6'h22 : (code >= 6'h20) ? 6'h20 :
                   (code >= 6'h1e) ? 6'h1e : (code >= 6'h1c) ? 6'h1c :
                   (code >= 6'h19) ? 6'h19 : (code >= 6'h18) ? 6'h18 :
                   (code >= 6'h15) ? 6'h15 : (code >= 6'h14) ? 6'h14 :
                   (code >= 6'h12) ? 6'h12 : (code >= 6'h11) ? 6'h11 :
                   (code >= 6'h10) ? 6'h10 : (code >= 6'h0f) ? 6'h0f :
                   (code >= 6'h0e) ? 6'h0e : (code >= 6'h0c) ? 6'h0c :
                   (code >= 6'h0a) ? 6'h0a : (code >= 6'h09) ? 6'h09 :
                   FACTOR_MIN;
    assign factor_n = (code >= FACTOR_MAX) ? FACTOR_MAX : n_mid; // R01
endmodule

// [src/pllcc_top.sv]
// modulator clock source control: registers, lock, divider, sequencing
`timescale 1ns/1ns
// Rules this block is built around
// R01 - decode 6-bit code to factor: 0..8 give 8, 42 up give 42
// R02 - oscillator runs at reference times decoded factor when in use
// R03 - modulator clock is oscillator divided by two, even duty
// R04 - host writes factor code before setting the enable bit
// R05 - locked state shows in bit 7 of factor/lock register
// R06 - host clears and resets enable after changing the code
// R07 - host writes 4 to the enable register to start the loop
// R08 - host order: clock, factor, enable, autoband, converter reset
// R09 - host finally writes desired converter setting
// R10 - after reset run direct clocking, loop bypassed
// R11 - internal reference on by default, off when bit 6 set
// R12 - bandwidth equals modulator clock divided by 64
// R13 - reference must lie within 30 to 160 MHz in multiplier mode; not checked here
// R14 - modulator clock must stay within 5 percent of nominal; not checked here
// R15 - bit 6 enables autoband; toggling restarts band detection
// R16 - lock bit reads zero while disabled or unlocked
module pllcc_top
    import pllcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_ff,
    input wire logic lock_raw,
    output pllcc_cfg_t cfg_ff,
    output logic mod_clk_ff,
    output logic bw_tick_ff,
    output logic autoband_start_ff,
    output logic rate_reset_ff
);
    logic [7:0] enable_reg_ff;
    logic [5:0] code_ff;
    logic autoband_ff;
    logic [7:0] ref_reg_ff;
    logic [5:0] rate_ff;
    logic lock_s1_ff;
    logic lock_s2_ff;
    logic locked_ff;
    logic [6:0] bw_cnt_ff;
    logic [5:0] factor_dec;

    // address decode
    wire logic hit_en;
    wire logic hit_fl;
    wire logic hit_ref;
    wire logic hit_rate;
    wire logic wr_en;
    wire logic wr_fl;
    wire logic wr_ref;
    wire logic wr_rate;
    assign hit_en = (reg_addr == OFS_PLL_ENABLE_CTRL);
    assign hit_fl = (reg_addr == OFS_PLL_FACTOR_LOCK_CTRL);
    assign hit_ref = (reg_addr == OFS_REFERENCE_CTRL);
    assign hit_rate = (reg_addr == OFS_RATE_CONVERTER_CTRL);
    assign wr_en = reg_wr && hit_en;
    assign wr_fl = reg_wr && hit_fl;
    assign wr_ref = reg_wr && hit_ref;
    assign wr_rate = reg_wr && hit_rate;

    // next values
    wire logic [7:0] nxt_enable_reg;
    wire logic nxt_autoband;
    wire logic loop_en;
    wire logic nxt_locked;
    wire logic [7:0] fl_view;
    wire logic [7:0] nxt_reg_rdata;
    wire logic bw_wrap;
    assign nxt_enable_reg = wr_en ? reg_wdata : enable_reg_ff; // R07
    assign loop_en = enable_reg_ff[POS_LOOP_ENABLE];
    assign nxt_autoband = wr_fl ? reg_wdata[POS_AUTOBAND] : autoband_ff;
    // lock drops with the enable write itself, not a cycle later
    assign nxt_locked = nxt_enable_reg[POS_LOOP_ENABLE] && lock_s2_ff; // R16
    assign fl_view = {locked_ff, autoband_ff, code_ff}; // R05
    assign nxt_reg_rdata = !reg_rd ? 8'h00 :
                           hit_en ? enable_reg_ff :
                           hit_fl ? fl_view :
                           hit_ref ? ref_reg_ff :
                           hit_rate ? {2'b00, rate_ff} : 8'h00;
    assign bw_wrap = (bw_cnt_ff == BW_CNT_LAST);

    pllcc_factor_decode u_decode (
        .code(code_ff),
        .factor_n(factor_dec)
    );

    // lock comes from the analog loop, so it is synchronised first
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
        end else begin
            lock_s1_ff <= lock_raw;
            lock_s2_ff <= lock_s1_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_reg_ff <= RST_PLL_ENABLE_CTRL; // R10
            code_ff <= RST_FACTOR_CODE;
            autoband_ff <= 1'b0;
            ref_reg_ff <= RST_REFERENCE_CTRL; // R11
            rate_ff <= RST_RATE_CONVERTER;
            locked_ff <= 1'b0;
        end else begin
            enable_reg_ff <= nxt_enable_reg;
            code_ff <= wr_fl ? reg_wdata[5:0] : code_ff;
            autoband_ff <= nxt_autoband; // R15
            ref_reg_ff <= wr_ref ? reg_wdata : ref_reg_ff;
            rate_ff <= wr_rate ? reg_wdata[5:0] : rate_ff; // R09
            locked_ff <= nxt_locked; // R05
        end
    end

    // readback and event pulses
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= 8'h00;
            autoband_start_ff <= 1'b0;
            rate_reset_ff <= 1'b0;
        end else begin
            reg_rdata_ff <= nxt_reg_rdata;
            autoband_start_ff <= nxt_autoband && !autoband_ff; // R15
            rate_reset_ff <= wr_rate && (reg_wdata[5:0] == 6'h00); // R08
        end
    end

    // configuration toward the analog side
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff.loop_en <= loop_en;
            // stay on the direct clock until the loop reports lock
            cfg_ff.mod_src_pll <= loop_en && locked_ff; // R10
            cfg_ff.autoband_en <= autoband_ff;
            cfg_ff.vref_int_en <= !ref_reg_ff[POS_VREF_OFF]; // R11
            cfg_ff.factor_n <= factor_dec; // R02
            cfg_ff.rate_setting <= rate_ff;
        end
    end

    // sys_clk stands in for the oscillator here; real divider is analog
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mod_clk_ff <= 1'b0;
            bw_cnt_ff <= 7'h00;
            bw_tick_ff <= 1'b0;
        end else begin
            mod_clk_ff <= !mod_clk_ff; // R03
            bw_cnt_ff <= bw_wrap ? 7'h00 : bw_cnt_ff + 7'h01;
            bw_tick_ff <= bw_wrap; // R12
        end
    end

    // all checks run on sys_clk and sleep through reset
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // lock reporting
    a_lock_needs_en: assert property ( // R16
        locked_ff |-> enable_reg_ff[POS_LOOP_ENABLE])
        else $error("lock shown while loop disabled");
    a_lock_drop_now: assert property ( // R16
        (wr_en && !reg_wdata[POS_LOOP_ENABLE]) |=> !locked_ff)
        else $error("lock not cleared with enable");
    a_lock_follows: assert property ( // R05
        (loop_en && lock_s2_ff && !wr_en) |=> locked_ff)
        else $error("lock not reported");
    a_lock_readback: assert property ( // R05
        (reg_rd && hit_fl) |=> reg_rdata_ff[POS_LOCKED] == $past(locked_ff))
        else $error("lock bit readback wrong");

    // factor decode, clock source and internal reference
    a_factor_range: assert property ( // R01
        (code_ff >= FACTOR_MAX) |=> cfg_ff.factor_n == FACTOR_MAX)
        else $error("factor not clamped high");
    a_factor_low: assert property ( // R01
        (code_ff <= FACTOR_MIN) |=> cfg_ff.factor_n == FACTOR_MIN)
        else $error("factor not clamped low");
    a_direct_unlocked: assert property ( // R10
        !locked_ff |=> !cfg_ff.mod_src_pll)
        else $error("loop clock used without lock");
    a_src_on_lock: assert property ( // R02
        (loop_en && locked_ff) |=> cfg_ff.mod_src_pll)
        else $error("loop clock not used after lock");
    a_vref_off: assert property ( // R11
        (wr_ref && reg_wdata[POS_VREF_OFF]) |=> ##1 !cfg_ff.vref_int_en)
        else $error("internal reference not disabled");

    // clocks, ticks and event pulses
    a_mod_half: assert property ( // R03
        mod_clk_ff |=> !mod_clk_ff ##1 mod_clk_ff)
        else $error("modulator clock not half rate");
    a_bw_period: assert property ( // R12
        bw_tick_ff |=> !bw_tick_ff [*8])
        else $error("bandwidth tick too frequent");
    a_bw_tick_zero: assert property ( // R12
        bw_tick_ff |-> (bw_cnt_ff == 7'h00))
        else $error("bandwidth tick off its count");
    a_bw_step: assert property ( // R12
        (bw_cnt_ff != BW_CNT_LAST) |=> bw_cnt_ff == $past(bw_cnt_ff) + 7'h01)
        else $error("bandwidth count skipped");
    a_band_restart: assert property ( // R15
        (wr_fl && reg_wdata[POS_AUTOBAND] && !autoband_ff)
        |=> autoband_start_ff ##1 !autoband_start_ff)
        else $error("autoband restart pulse missing");
    a_rate_reset: assert property ( // R08
        (wr_rate && reg_wdata[5:0] == 6'h00) |=> rate_reset_ff)
        else $error("converter reset pulse missing");
    a_rate_keep: assert property ( // R09
        (wr_rate && reg_wdata[5:0] != 6'h00) |=> !rate_reset_ff)
        else $error("converter reset on nonzero setting");

    c_locked: cover property (!locked_ff ##1 locked_ff);
    c_pll_src: cover property (cfg_ff.mod_src_pll ##1 !cfg_ff.mod_src_pll);
    c_rate_reset: cover property (
        rate_reset_ff ##[1:20] (wr_rate && reg_wdata[5:0] != 6'h00));
    c_factor_max: cover property (cfg_ff.factor_n == FACTOR_MAX);
endmodule

// [bench/pllcc_loop_model.sv]
// loop lock source model: lock a set time after enable
`timescale 1ns/1ns
module pllcc_loop_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic loop_en,
    input wire logic [7:0] lock_dly,
    output logic lock_raw
);
    logic [7:0] cnt_ff;
    // reference taken as in range, so lock always comes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 8'h00;
            lock_raw <= 1'b0;
        end else if (!loop_en) begin
            cnt_ff <= 8'h00; // enable drop restarts acquisition
            lock_raw <= 1'b0;
        end else if (cnt_ff == lock_dly) begin
            lock_raw <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the modulator clock control block
`timescale 1ns/1ns
module tb_top;
    import pllcc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata_ff, lock_dly;
    logic lock_raw, mod_clk_ff, bw_tick_ff, autoband_start_ff, rate_reset_ff;
    pllcc_cfg_t cfg_ff;
    logic [7:0] exp_q[$];
    logic rd_q = 1'b0;
    logic [5:0] c;
    int n_mismatch = 0;
    int checked = 0;
    int i, k;
    always #2 sys_clk = ~sys_clk;
    pllcc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .lock_raw(lock_raw), .cfg_ff(cfg_ff),
        .mod_clk_ff(mod_clk_ff), .bw_tick_ff(bw_tick_ff),
        .autoband_start_ff(autoband_start_ff), .rate_reset_ff(rate_reset_ff));
    pllcc_loop_model loop (.sys_clk(sys_clk), .rst_b(rst_b),
        .loop_en(cfg_ff.loop_en), .lock_dly(lock_dly), .lock_raw(lock_raw));
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang();
        n_mismatch++;
        test_done();
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge sys_clk);
        reg_rd = 1'b0;
    endtask
    // one-cycle pulses: count high samples over four cycles
    task automatic pulse(input logic sel, input logic [7:0] e, string nm);
        int h;
        h = 0;
        repeat (4) begin
            // look first: the pulse is already up when wr returns
            if ((sel ? rate_reset_ff : autoband_start_ff) === 1'b1) h++;
            @(negedge sys_clk);
        end
        chk(nm, e, 8'(h));
    endtask
    function automatic logic [7:0] exp_n(input logic [5:0] v);
        logic [7:0] t[16] = '{8'h09, 8'h0a, 8'h0c, 8'h0e, 8'h0f, 8'h10,
            8'h11, 8'h12, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1c, 8'h1e,
            8'h20, 8'h22};
        exp_n = 8'h08;
        for (int j = 0; j < 16; j++) if (t[j] <= {2'b00, v}) exp_n = t[j];
        if (v >= 6'h2a) exp_n = 8'h2a;
    endfunction
    always @(posedge sys_clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) chk("read queue", 8'h00, 8'h01);
            else chk("read data", exp_q.pop_front(), reg_rdata_ff);
        end
        rd_q <= reg_rd;
    end
    initial begin
        lock_dly = 8'h01;
        void'($urandom(32'hb2e6));
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        chk("src", 8'h00, {7'h00, cfg_ff.mod_src_pll});
        chk("vref", 8'h01, {7'h00, cfg_ff.vref_int_en});
        rd(10'h009, 8'h00);
        rd(10'h00a, 8'h00);
        rd(10'h3ff, 8'h00);
        for (i = 0; i < 72; i++) begin
            c = (i < 64) ? 6'(i) : 6'($urandom);
            wr(10'h00a, {2'b00, c});
            repeat (2) @(negedge sys_clk);
            chk("factor", exp_n(c), {2'b00, cfg_ff.factor_n});
            rd(10'h00a, {2'b00, c});
        end
        // second pass is a slow relock at a new factor
        for (i = 0; i < 2; i++) begin
            lock_dly = i ? 8'h40 : 8'h01;
            c = i ? 6'h2a : 6'h11;
            wr(10'h00a, {2'b00, c});
            wr(10'h009, 8'h04);
            for (k = 0; k < 90 && cfg_ff.mod_src_pll !== 1'b1; k++)
                @(negedge sys_clk);
            if (k == 90) hang();
            rd(10'h00a, {2'b10, c});
            rd(10'h009, 8'h04);
            wr(10'h009, 8'h00);
            rd(10'h00a, {2'b00, c});
            chk("src", 8'h00, {7'h00, cfg_ff.mod_src_pll});
        end
        wr(10'h00a, 8'h51);
        pulse(1'b0, 8'h01, "autoband start");
        chk("autoband", 8'h01, {7'h00, cfg_ff.autoband_en});
        wr(10'h00a, 8'h11);
        wr(10'h00a, 8'h51);
        pulse(1'b0, 8'h01, "autoband restart");
        wr(10'h101, 8'h00);
        pulse(1'b1, 8'h01, "rate reset");
        wr(10'h101, 8'hff);
        pulse(1'b1, 8'h00, "rate no reset");
        rd(10'h101, 8'h3f);
        chk("rate", 8'h3f, {2'b00, cfg_ff.rate_setting});
        wr(10'h018, 8'h40);
        repeat (2) @(negedge sys_clk);
        chk("vref off", 8'h00, {7'h00, cfg_ff.vref_int_en});
        rd(10'h018, 8'h40);
        for (k = 0; k < 200 && bw_tick_ff !== 1'b1; k++) @(negedge sys_clk);
        if (k == 200) hang();
        for (k = 1; k < 200; k++) begin
            c[0] = mod_clk_ff;
            @(negedge sys_clk);
            chk("mod clk", {7'h00, ~c[0]}, {7'h00, mod_clk_ff});
            if (bw_tick_ff === 1'b1) break;
        end
        chk("bw period", 8'd128, 8'(k));
        repeat (3) @(negedge sys_clk);
        test_done();
    end
endmodule
